/* File: src/mpc_map.svh */
// Register offsets, field positions, reset values and constants of the context controller
`ifndef MPC_MAP_SVH
`define MPC_MAP_SVH
`define MPC_NUM_REG_MASTERS 3
`define MPC_NUM_DMA 2
`define MPC_NUM_GUARDS 8
`define MPC_SECURE_CPU 3'h0
`define MPC_MASTER_STRIDE_BIT 4
`define MPC_OFS_CTRL 2'h0
`define MPC_OFS_CTX 2'h1
`define MPC_OFS_IRQ_STAT 12'h100
`define MPC_OFS_IRQ_MASK 12'h104
`define MPC_BIT_PRIV 0
`define MPC_BIT_SECSEL 1
`define MPC_MASK_LSB 16
`define MPC_CTX_LSB 0
`define MPC_STASH_LSB 8
`define MPC_RST_CTX 4'h1
`define MPC_RST_MASK 16'h0001
`define MPC_RST_PRIV 1'b1
`define MPC_RST_SECSEL 1'b1
`define MPC_CTX_ZERO 4'h0
`define MPC_RESET_VECTOR_ADDR 32'h0000_0004
`define MPC_TRUSTED_HANDLER_ADDR 32'h0000_0101
`define MPC_EV_VIOLATION 0
`define MPC_EV_DENIED 1
`define MPC_EV_CTX0_ENTRY 2
`define MPC_NUM_EVENTS 3
`define MPC_HTRANS_NONSEQ 2'h2
`define MPC_HTRANS_SEQ 2'h3
`endif

/* File: src/mpc_pkg.sv */
// Types shared by the master protection context controller
package mpc_pkg;
  typedef struct packed {
    logic priv;
    logic ns;
    logic exec;
    logic [3:0] ctx;
  } mpc_attr_t;

  typedef struct packed {
    logic valid;
    logic [2:0] master;
    logic write;
    logic has_priv;
    logic priv;
    logic has_ns;
    logic ns;
    logic has_exec;
    logic exec;
    logic [31:0] addr;
  } mpc_req_t;

  typedef struct packed {
    logic valid;
    logic [2:0] master;
    logic write;
    logic [31:0] addr;
    mpc_attr_t attr;
  } mpc_xfer_t;

  typedef struct packed {
    logic valid;
    logic chan;
    logic [2:0] owner;
    logic has_priv;
    logic priv;
  } mpc_dma_cfg_t;
endpackage : mpc_pkg

/* File: src/mpc_ctrl.sv */
// Master protection attribute and protection context controller with AHB-Lite registers
//
// Summary of operation
// R1: Untagged masters get privilege from register field
// R2: Untagged masters get security from secure_select
// R3: Missing execute indication forces execute to zero
// R4: DMA channels inherit owner's privilege, security, context
// R5: DMA channels have no own context registers
// R6: Each master's current_context tags its transfers
// R7: Context write k lands only if mask bit k
// R8: Context owner-writable; mask writable by secure CPU
// R9: Stash and context-zero entry only on secure CPU
// R10: Secure CPU reset forces context zero
// R11: Exception entry to trusted handler enters context zero
// R12: Entry stashes old context, then clears current
// R13: Context zero bypasses all guards and attributes
// R14: Contexts reset to one; mask bit zero set
// R15: Trusted software restores context from stash
// R16: Rejected transfer ends in error, not performed
// R17: Rejected transfer described to fault report
// R18: Guards evaluated highest first, no match allows
// R19: Refused context write still completes without error
`timescale 1ns/1ps
`include "mpc_map.svh"

module mpc_ctrl
  import mpc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [3:0] hmaster,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire mpc_req_t req,
  input wire mpc_dma_cfg_t dma_cfg,
  input wire logic scpu_reset_entry,
  input wire logic scpu_vec_valid,
  input wire logic [31:0] scpu_vec_addr,
  input wire logic [`MPC_NUM_GUARDS-1:0] guard_hit,
  input wire logic [`MPC_NUM_GUARDS-1:0] guard_allow,
  output mpc_xfer_t eval_xfer,
  output logic xfer_done,
  output logic xfer_error,
  output mpc_xfer_t fault_report,
  output logic irq
);

  localparam int NM = `MPC_NUM_REG_MASTERS;
  localparam int ND = `MPC_NUM_DMA;
  localparam int NG = `MPC_NUM_GUARDS;
  localparam int NE = `MPC_NUM_EVENTS;

  typedef struct packed {
    logic d_act;
    logic d_write;
    logic [11:0] d_addr;
    logic [3:0] d_master;
    logic [NM-1:0] priv_f;
    logic [NM-1:0] secsel_f;
    logic [NM-1:0][15:0] mask;
    logic [NM-1:0][3:0] ctx;
    logic [3:0] stash;
    mpc_attr_t [ND-1:0] dma_attr;
    mpc_xfer_t stg;
    logic done;
    logic err;
    mpc_xfer_t fault;
    logic [NE-1:0] stat;
    logic [NE-1:0] irq_mask;
    logic [31:0] rdata;
  } mpc_state_t;

  mpc_state_t st_reg;
  mpc_state_t st_next;

  ////////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  // Register master index from a word address, or all ones when out of range
  function automatic logic [3:0] reg_master(input logic [11:0] a);
    if (a[11:8] == 4'h0 && a[7:`MPC_MASTER_STRIDE_BIT] < 4'(NM)) begin
      return a[7:`MPC_MASTER_STRIDE_BIT];
    end
    return 4'hF;
  endfunction : reg_master

  // Resolve the attributes of a transfer from a master with a register set
  function automatic mpc_attr_t resolve(input mpc_state_t s, input logic [1:0] m,
                                        input logic hp, input logic p,
                                        input logic hn, input logic n,
                                        input logic hx, input logic x);
    mpc_attr_t a;
    a.priv = hp ? p : s.priv_f[m]; // see R1
    a.ns = hn ? n : s.secsel_f[m]; // see R2
    a.exec = hx ? x : 1'b0; // see R3
    a.ctx = s.ctx[m]; // see R6
    return a;
  endfunction : resolve

  ////////////////////////////////////////////////////////////////////////////////
  // Guard priority: the highest structure that hits decides

  logic guard_ok;
  always_comb begin
    guard_ok = 1'b1; // see R18
    for (int g = 0; g < NG; g++) begin
      if (guard_hit[g]) begin
        guard_ok = guard_allow[g]; // see R18
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  logic [3:0] wm;
  logic [3:0] am;
  logic [31:0] rd;
  logic [NE-1:0] ev;
  logic [NE-1:0] w1c;
  logic hw_entry;
  logic [3:0] want;

  always_comb begin
    st_next = st_reg;
    ev = '0;
    w1c = '0;
    rd = 32'h0000_0000;
    want = hwdata[`MPC_CTX_LSB +: 4];
    wm = reg_master(st_reg.d_addr);
    am = reg_master(haddr[11:0]);

    // Context-zero entry exists for the secure CPU only
    hw_entry = scpu_reset_entry; // see R9, R10
    if (scpu_vec_valid && scpu_vec_addr == `MPC_TRUSTED_HANDLER_ADDR) begin
      hw_entry = 1'b1; // see R11
    end

    // Bus data phase: writes
    if (st_reg.d_act && st_reg.d_write) begin
      if (wm != 4'hF) begin
        if (st_reg.d_addr[3:2] == `MPC_OFS_CTRL) begin
          // Only the secure CPU may reshape privilege, security and mask
          if (st_reg.d_master == 4'(`MPC_SECURE_CPU)) begin // see R8
            st_next.priv_f[wm[1:0]] = hwdata[`MPC_BIT_PRIV];
            st_next.secsel_f[wm[1:0]] = hwdata[`MPC_BIT_SECSEL];
            st_next.mask[wm[1:0]] = hwdata[`MPC_MASK_LSB +: 16] | `MPC_RST_MASK; // see R14
          end else begin
            ev[`MPC_EV_DENIED] = 1'b1;
          end
        end else if (st_reg.d_addr[3:2] == `MPC_OFS_CTX) begin
          if (st_reg.d_master != wm && st_reg.d_master != 4'(`MPC_SECURE_CPU)) begin
            ev[`MPC_EV_DENIED] = 1'b1; // see R8
          end else if (st_reg.mask[wm[1:0]][want]) begin
            st_next.ctx[wm[1:0]] = want; // see R7
          end else begin
            ev[`MPC_EV_DENIED] = 1'b1; // see R7, R19
          end
          // Stash is writable so trusted code can park and restore it
          if (wm == 4'(`MPC_SECURE_CPU) && st_reg.d_master == 4'(`MPC_SECURE_CPU)) begin
            st_next.stash = hwdata[`MPC_STASH_LSB +: 4]; // see R15
          end
        end
      end else if (st_reg.d_addr == `MPC_OFS_IRQ_STAT) begin
        w1c = hwdata[NE-1:0];
      end else if (st_reg.d_addr == `MPC_OFS_IRQ_MASK) begin
        st_next.irq_mask = hwdata[NE-1:0];
      end
    end

    // Hardware entry overrides a same-cycle software context write
    if (hw_entry) begin
      st_next.stash = st_reg.ctx[`MPC_SECURE_CPU]; // see R12
      st_next.ctx[`MPC_SECURE_CPU] = `MPC_CTX_ZERO; // see R10, R12
      ev[`MPC_EV_CTX0_ENTRY] = 1'b1;
    end

    // Bus address phase: capture and prefetch read data
    if (hready) begin
      st_next.d_act = hsel && (htrans == `MPC_HTRANS_NONSEQ || htrans == `MPC_HTRANS_SEQ);
      st_next.d_write = hwrite;
      st_next.d_addr = {haddr[11:2], 2'b00};
      st_next.d_master = hmaster;
      if (am != 4'hF) begin
        if (haddr[3:2] == `MPC_OFS_CTRL) begin
          rd[`MPC_BIT_PRIV] = st_reg.priv_f[am[1:0]];
          rd[`MPC_BIT_SECSEL] = st_reg.secsel_f[am[1:0]];
          rd[`MPC_MASK_LSB +: 16] = st_reg.mask[am[1:0]];
        end else if (haddr[3:2] == `MPC_OFS_CTX) begin
          rd[`MPC_CTX_LSB +: 4] = st_reg.ctx[am[1:0]];
          if (am == 4'(`MPC_SECURE_CPU)) begin
            rd[`MPC_STASH_LSB +: 4] = st_reg.stash; // see R9
          end
        end
      end else if ({haddr[11:2], 2'b00} == `MPC_OFS_IRQ_STAT) begin
        rd[NE-1:0] = st_reg.stat;
      end else if ({haddr[11:2], 2'b00} == `MPC_OFS_IRQ_MASK) begin
        rd[NE-1:0] = st_reg.irq_mask;
      end
      st_next.rdata = rd;
    end

    // DMA channels take the configuring master's attributes
    if (dma_cfg.valid && dma_cfg.owner < 3'(NM)) begin
      st_next.dma_attr[dma_cfg.chan] = resolve(st_reg, dma_cfg.owner[1:0],
        dma_cfg.has_priv, dma_cfg.priv, 1'b0, 1'b0, 1'b0, 1'b0); // see R4
    end

    // Stage one: attach attributes to the incoming transfer
    st_next.stg.valid = req.valid;
    st_next.stg.master = req.master;
    st_next.stg.write = req.write;
    st_next.stg.addr = req.addr;
    if (req.master < 3'(NM)) begin
      st_next.stg.attr = resolve(st_reg, req.master[1:0], req.has_priv, req.priv,
                                 req.has_ns, req.ns, req.has_exec, req.exec);
    end else begin
      // No registers exist for DMA; attributes come only from inheritance
      // Master code NM is channel 0 and NM+1 channel 1
      st_next.stg.attr = st_reg.dma_attr[req.master != 3'(NM)]; // see R4, R5
      st_next.stg.attr.exec = 1'b0; // see R3
    end

    // Stage two: guard verdict on the staged transfer
    st_next.done = 1'b0;
    st_next.err = 1'b0;
    st_next.fault.valid = 1'b0;
    if (st_reg.stg.valid) begin
      if (st_reg.stg.attr.ctx == `MPC_CTX_ZERO || guard_ok) begin // see R13
        st_next.done = 1'b1;
      end else begin
        st_next.err = 1'b1; // see R16
        st_next.fault = st_reg.stg; // see R17
        ev[`MPC_EV_VIOLATION] = 1'b1;
      end
    end

    // Set wins over a same-cycle write-one-to-clear
    st_next.stat = (st_reg.stat & ~w1c) | ev;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg <= '0;
      st_reg.priv_f <= {NM{`MPC_RST_PRIV}};
      st_reg.secsel_f <= {NM{`MPC_RST_SECSEL}};
      st_reg.mask <= {NM{`MPC_RST_MASK}}; // see R14
      st_reg.ctx <= {NM{`MPC_RST_CTX}}; // see R14
      st_reg.stash <= `MPC_RST_CTX; // see R14
      st_reg.dma_attr <= {ND{{1'b1, 1'b1, 1'b0, `MPC_RST_CTX}}};
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Zero wait states: read data is prepared during the address phase
  assign hreadyout = 1'b1;
  assign hresp = 1'b0; // see R19
  assign hrdata = st_reg.rdata;
  // Guards see the staged transfer; context zero is masked off and passes whatever the guards answer
  always_comb begin
    eval_xfer = st_reg.stg;
    eval_xfer.valid = st_reg.stg.valid && st_reg.stg.attr.ctx != `MPC_CTX_ZERO; // see R13
  end
  assign xfer_done = st_reg.done;
  assign xfer_error = st_reg.err; // see R16
  assign fault_report = st_reg.fault; // see R17
  assign irq = |(st_reg.stat & st_reg.irq_mask);

endmodule : mpc_ctrl

/* File: verif/mpc_ctrl_asserts.sv */
// Port assertions for the context controller
`timescale 1ns/1ps
`include "mpc_map.svh"
module mpc_ctrl_asserts
  import mpc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire mpc_req_t req,
  input wire logic scpu_reset_entry,
  input wire logic scpu_vec_valid,
  input wire logic [31:0] scpu_vec_addr,
  input wire logic [`MPC_NUM_GUARDS-1:0] guard_hit,
  input wire logic [`MPC_NUM_GUARDS-1:0] guard_allow,
  input wire mpc_xfer_t eval_xfer,
  input wire logic xfer_done,
  input wire logic xfer_error,
  input wire mpc_xfer_t fault_report
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready okay");
  a_exec_zero: assert property (req.valid && !req.has_exec
    |=> !eval_xfer.attr.exec) else $error("execute not forced low");
  a_ctx_live: assert property (eval_xfer.valid |-> eval_xfer.attr.ctx != 4'h0)
    else $error("context zero transfer reached guards");
  a_open_pass: assert property (eval_xfer.valid && !guard_hit
    |=> xfer_done && !xfer_error) else $error("unmatched transfer not allowed");
  a_deny_error: assert property (eval_xfer.valid && guard_hit != 0
    && guard_allow == 0 |=> xfer_error && !xfer_done) else $error("denied transfer done");
  a_fault_pair: assert property (xfer_error
    |-> fault_report.valid && fault_report.addr == $past(eval_xfer.addr))
    else $error("fault report missing");
  a_trusted_entry: assert property (scpu_vec_valid
    && scpu_vec_addr == `MPC_TRUSTED_HANDLER_ADDR ##1 req.valid && req.master == 3'h0
    |=> !eval_xfer.valid) else $error("trusted entry kept context");
  a_reset_entry: assert property (scpu_reset_entry
    ##1 req.valid && req.master == 3'h0 |=> !eval_xfer.valid)
    else $error("secure reset kept context");
endmodule : mpc_ctrl_asserts
bind mpc_ctrl mpc_ctrl_asserts mpc_ctrl_asserts_i (.clk, .reset, .hreadyout, .hresp, .req,
  .scpu_reset_entry, .scpu_vec_valid, .scpu_vec_addr, .guard_hit, .guard_allow,
  .eval_xfer, .xfer_done, .xfer_error, .fault_report);

/* File: verif/mpc_guard_model.sv */
// Region guard model answering the staged transfer
`timescale 1ns/1ps
module mpc_guard_model
  import mpc_pkg::*;
(
  input wire mpc_xfer_t eval_xfer,
  output logic [7:0] guard_hit,
  output logic [7:0] guard_allow
);
  // Hits and verdicts ride in the address; idle cycles show the inverse, never stale values
  always_comb begin
    guard_hit = eval_xfer.valid ? eval_xfer.addr[15:8] : ~eval_xfer.addr[15:8];
    guard_allow = eval_xfer.valid ? eval_xfer.addr[7:0] : ~eval_xfer.addr[7:0];
  end
endmodule : mpc_guard_model

/* File: verif/tb.sv */
// Self-checking bench of the context controller with a reference model
`timescale 1ns/1ps
`include "mpc_map.svh"
module tb
  import mpc_pkg::*;
;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [3:0] hmaster = 4'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] scpu_vec_addr = 32'h0;
  logic scpu_reset_entry = 1'b0;
  logic scpu_vec_valid = 1'b0;
  mpc_req_t req = '0;
  mpc_dma_cfg_t dma_cfg = '0;
  logic hreadyout, hresp, xfer_done, xfer_error, irq;
  logic [31:0] hrdata;
  logic [7:0] guard_hit, guard_allow;
  mpc_xfer_t eval_xfer, fault_report;
  int bad_count = 0;
  int checks = 0;
  int ctx[5] = '{1, 1, 1, 1, 1};
  int pv[5] = '{1, 1, 1, 1, 1};
  int sec[5] = '{1, 1, 1, 1, 1};
  int msk[3] = '{1, 1, 1};
  int stash = 1;
  int stat = 0;
  int imsk = 0;
  int iq[$] = '{4, 3, 7};
  logic [31:0] at[$] = '{32'h0, 32'h8080, 32'h8001, 32'h0301, 32'h0100};

  always #2.5 clk = ~clk;

  mpc_ctrl mpc_ctrl_i (.clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hmaster, .hreadyout, .hresp, .hrdata, .req, .dma_cfg,
    .scpu_reset_entry, .scpu_vec_valid, .scpu_vec_addr, .guard_hit, .guard_allow,
    .eval_xfer, .xfer_done, .xfer_error, .fault_report, .irq);
  mpc_guard_model mpc_guard_model_i (.eval_xfer, .guard_hit, .guard_allow);

  task automatic complete_run();
    if (bad_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run

  task automatic check(input logic [63:0] s, input logic [63:0] x);
    checks++;
    if (s !== x) begin
      bad_count++;
      $display("mismatch at %0t: saw %h want %h", $time, s, x);
    end
  endtask : check

  // Waits on hready at rising edges; a stuck bus ends the run
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      bad_count++;
      complete_run();
    end
  endtask : wait_ready

  task automatic bus(input logic [3:0] m, input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    hmaster <= m;
    hsel <= 1'b1;
    htrans <= `MPC_HTRANS_NONSEQ;
    haddr <= {20'h0, a};
    hwrite <= w;
    wait_ready();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_ready();
    q = hrdata;
  endtask : bus

  function automatic logic [31:0] exp_rd(input int a);
    int i;
    i = a / 16;
    if (a == 'h100) return stat;
    if (a == 'h104) return imsk;
    if (i > 2) return 0;
    if (a % 16 == 0) return {msk[i][15:0], 14'h0, sec[i][0], pv[i][0]};
    if (a % 16 == 4) return {20'h0, i == 0 ? stash[3:0] : 4'h0, 4'h0, ctx[i][3:0]};
    return 0;
  endfunction : exp_rd

  task automatic rd(input int a);
    logic [31:0] q;
    bus(4'h0, 1'b0, a[11:0], 32'h0, q);
    check(q, exp_rd(a));
  endtask : rd

  task automatic wr(input int m, input int a, input logic [31:0] d);
    logic [31:0] q;
    int i;
    i = a / 16;
    bus(m[3:0], 1'b1, a[11:0], d, q);
    if (a == 'h100) stat &= ~d;
    else if (a == 'h104) imsk = d[2:0];
    else if (a % 16 == 0 && m != 0) stat |= 2;
    else if (a % 16 == 0) begin
      pv[i] = d[0];
      sec[i] = d[1];
      msk[i] = d[31:16] | 1;
    end else if (m != 0 && m != i) stat |= 2;
    else if (msk[i][d[3:0]]) ctx[i] = d[3:0];
    else stat |= 2;
    if (a == 'h04 && m == 0) stash = d[11:8];
  endtask : wr

  function automatic bit open_for(input logic [31:0] a);
    for (int i = 7; i >= 0; i--) if (a[8 + i]) return a[i];
    return 1'b1;
  endfunction : open_for

  task automatic xfer(input int m, input bit nat, input logic [31:0] a);
    logic [2:0] r;
    mpc_attr_t t;
    mpc_xfer_t e;
    bit ok;
    r = $urandom;
    t = '{nat ? r[1] : pv[m][0], nat ? r[2] : sec[m][0], nat & r[0], ctx[m][3:0]};
    e = '{1'b1, m[2:0], r[0], a, t};
    ok = ctx[m] == 0 || open_for(a);
    req <= '{1'b1, m[2:0], r[0], nat, r[1], nat, r[2], nat, r[0], a};
    @(posedge clk);
    req <= '0;
    @(negedge clk);
    if (ctx[m] == 0) check(eval_xfer.valid, 1'b0);
    else check(eval_xfer, e);
    @(negedge clk);
    check({xfer_done, xfer_error}, {ok, !ok});
    if (!ok) check(fault_report, e);
    stat |= !ok;
    @(posedge clk);
  endtask : xfer

  task automatic enter(input bit rst, input logic [31:0] v);
    scpu_reset_entry <= rst;
    scpu_vec_valid <= !rst;
    scpu_vec_addr <= v;
    @(posedge clk);
    scpu_reset_entry <= 1'b0;
    scpu_vec_valid <= 1'b0;
    if (rst || v == `MPC_TRUSTED_HANDLER_ADDR) begin
      stash = ctx[0];
      ctx[0] = 0;
      stat |= 4;
    end
  endtask : enter

  task automatic dcfg(input int ch, input int own);
    dma_cfg <= '{1'b1, ch[0], own[2:0], 1'b0, 1'b0};
    @(posedge clk);
    dma_cfg <= '0;
    ctx[3 + ch] = ctx[own];
    pv[3 + ch] = pv[own];
    sec[3 + ch] = sec[own];
  endtask : dcfg

  ////////////////////////////////////////////////////////////////
  initial begin
    int k;
    void'($urandom(28));
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 3; i++) begin
      rd(16 * i);
      rd(16 * i + 4);
    end
    k = $urandom;
    wr(0, 'h10, {k[15:0], 16'h0002});
    wr(1, 'h10, 32'h0);
    rd('h10);
    repeat (6) begin
      k = 1 + $urandom % 15;
      wr(1, 'h14, k);
      rd('h14);
    end
    wr(2, 'h14, 32'h1);
    rd('h14);
    rd('h200);
    foreach (iq[j]) begin
      wr(0, 'h104, iq[j]);
      rd('h100);
      check(irq, (stat & imsk) != 0);
    end
    wr(0, 'h100, 32'h7);
    rd('h100);
    check(irq, 1'b0);
    foreach (at[i]) xfer(1 + i % 2, i[0], at[i]);
    dcfg(0, 1);
    xfer(3, 1'b0, 32'h8080);
    dcfg(1, 2);
    xfer(4, 1'b0, 32'h0100);
    wr(0, 'h00, 32'h0006_0003);
    wr(0, 'h04, 32'h0000_0102);
    enter(1'b0, `MPC_TRUSTED_HANDLER_ADDR + 32'h4);
    rd('h04);
    enter(1'b0, `MPC_TRUSTED_HANDLER_ADDR);
    xfer(0, 1'b0, 32'h8001);
    rd('h04);
    wr(0, 'h04, {20'h0, stash[3:0], 4'h0, stash[3:0]});
    enter(1'b1, 32'h0);
    xfer(0, 1'b1, 32'h0100);
    rd('h04);
    rd('h100);
    check(irq, (stat & imsk) != 0);
    complete_run();
  end
endmodule : tb
